// >>> pisx_regs.vh
// Constants for the single-transfer initiator sequencer.
// Assumes inclusion by pisx_seq.v only; definitions only.
`ifndef PISX_REGS_VH
`define PISX_REGS_VH
`define PISX_ST_FATAL_HI   39
`define PISX_ST_FATAL_LO   38
`define PISX_ST_RETRY      36
`define PISX_CMD_PREFIX    3'h3
`define PISX_BYTE_EN_ALL   4'h0
`define PISX_ADDR_W        32
`endif

// >>> pisx_seq.v
// Single data-phase memory read/write initiator sequencer for a bus interface core.
// Assumes the core's user port is synchronous to mclk and that start/dir come from user logic.
`timescale 1ns/1ns
`include "pisx_regs.vh"

// What this block does
// - Idle waits for start, then requests
// - Direction high writes, held during transfer
// - Register phase flag, detect falling edge
// - Register extended status one clock later
// - Strobe clears flags; phase loads them
// - Request goes to write or read
// - Stay in transfer until phase falls
// - Exit to dead, retry or done
// - Dead holds until reset
// - Retry returns to request next clock
// - Done returns to idle next clock
// - Always ready before requesting bus
// - Ready resets low, then always high
// - Request is one-cycle pulse in request
// - Extended request held at zero
// - Drive address from request on, except while a data phase owns the bus
// - Command wherever the address is driven, else byte enables
// - Write direction follows dir, registered
// - Complete high in request and transfer
// - Ready, direction, complete driven by logic
// - Tolerate repeated address strobes
module pisx_seq #(
    parameter ADDR_W = `PISX_ADDR_W
) (
    // Clock and reset
    input  wire              mclk,
    input  wire              rst_n,
    // User side
    input  wire              start,
    input  wire              dir,
    input  wire [ADDR_W-1:0] target_addr,
    output reg               busy,
    output reg               dead,
    // Core initiator status
    input  wire              addr_strobe_n,
    input  wire              xfer_phase,
    input  wire [39:0]       core_ext_status,
    // Core initiator controls
    output reg               bus_request,
    output reg               extended_bus_ask,
    output reg               ready,
    output reg               complete,
    output reg               user_write_direction,
    output reg  [3:0]        user_cmd_byte_en,
    // Shared address/data bus, address path only
    output reg  [ADDR_W-1:0] shared_addr_data_bus_out,
    output reg               shared_addr_data_bus_oe
);

    // Sequence of one attempt, in clocks of mclk: start is taken in idle,
    // the request pulse and complete rise with the request state, then the
    // sequencer waits in the transfer state while the core arbitrates,
    // strobes for the address (possibly several times) and runs its data
    // phase. The clock after the data phase ends, the exit branch reads the
    // flags left by the last phase cycle, so a status that arrives later than
    // one clock after the bus event would be missed. Only reset leaves the
    // dead state; the user must provide some way to pull rst_n after an
    // abort, or the sequencer stays out of service for good.

    // One-hot state codes. The dead state keeps a bit of its own so that a
    // sequencer stuck after an abort shows in a single flip-flop.
    localparam [6:0] ST_IDLE  = 7'h01;
    localparam [6:0] ST_REQ   = 7'h02;
    localparam [6:0] ST_WRITE = 7'h04;
    localparam [6:0] ST_READ  = 7'h08;
    localparam [6:0] ST_RETRY = 7'h10;
    localparam [6:0] ST_DONE  = 7'h20;
    localparam [6:0] ST_DEAD  = 7'h40;

    reg  [6:0] state_reg;
    reg  [6:0] state_next;
    reg        xfer_phase_delayed;
    reg        fatal_reg;
    reg        retry_reg;
    reg        request_next;
    reg        complete_next;
    reg        busy_next;
    reg        dead_next;
    wire       xfer_phase_end_pulse;
    wire       state_merged_transfer;
    wire       attempt_over;
    wire       strobe_now;
    wire       live_next;
    wire       phase_owns_bus;

    // High in every state in which the core may still be working on our
    // request, so that the address and the command must stay presented.
    function is_live(input [6:0] st);
        is_live = (st == ST_REQ) || (st == ST_WRITE) || (st == ST_READ);
    endfunction

    // Exit of a finished attempt. An abort outranks a retry, because a
    // retried abort would only hit the same faulty target again.
    function [6:0] exit_state(input fatal_in, input retry_in);
        exit_state = fatal_in ? ST_DEAD : (retry_in ? ST_RETRY : ST_DONE);
    endfunction

    // Memory write for a high direction, memory read for a low one.
    function [3:0] mem_command(input wr);
        mem_command = {`PISX_CMD_PREFIX, wr};
    endfunction

    assign xfer_phase_end_pulse  = !xfer_phase & xfer_phase_delayed;
    assign state_merged_transfer = (state_reg == ST_WRITE) || (state_reg == ST_READ);
    assign attempt_over          = state_merged_transfer && xfer_phase_end_pulse;
    assign strobe_now            = !addr_strobe_n;
    assign live_next             = is_live(state_next);
    // While a data phase runs the core owns the shared bus; a fresh strobe
    // after lost grant hands the address path back to this block.
    assign phase_owns_bus        = xfer_phase && !strobe_now;

    // The copy resets low, the idle level of the phase flag, so no false end
    // of phase is seen in the first clock after reset.
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            xfer_phase_delayed <= 1'b0;
        end else begin
            xfer_phase_delayed <= xfer_phase;
        end
    end

    // Status is valid one clock after the bus event, so it is latched on
    // every phase cycle; the value left by the last phase is the one that
    // decides the exit. A strobe in the same cycle wins, since it opens a
    // new attempt for which the old status no longer applies. Status seen
    // outside a data phase is ignored on purpose.
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fatal_reg <= 1'b0;
            retry_reg <= 1'b0;
        end else if (strobe_now) begin
            fatal_reg <= 1'b0;
            retry_reg <= 1'b0;
        end else if (xfer_phase) begin
            fatal_reg <= core_ext_status[`PISX_ST_FATAL_HI] | core_ext_status[`PISX_ST_FATAL_LO];
            retry_reg <= core_ext_status[`PISX_ST_RETRY];
        end
    end

    // A rising start edge is not required: start held high simply issues a
    // new transaction after each done.
    always @* begin
        state_next = ST_IDLE;
        case (state_reg)
            ST_IDLE: begin
                state_next = start ? ST_REQ : ST_IDLE;
            end
            ST_REQ: begin
                state_next = dir ? ST_WRITE : ST_READ;
            end
            ST_WRITE, ST_READ: begin
                if (attempt_over)
                    state_next = exit_state(fatal_reg, retry_reg);
                else
                    state_next = state_reg;
            end
            ST_RETRY: begin
                state_next = ST_REQ;
            end
            ST_DONE: begin
                state_next = ST_IDLE;
            end
            ST_DEAD: begin
                state_next = ST_DEAD;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // The state register. An illegal code falls back to idle through the
    // default branch above rather than locking up.
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Output decode from the next state, so that every registered output is
    // valid in the very clock in which the state register enters that state.
    always @* begin
        request_next  = 1'b0;
        complete_next = 1'b0;
        busy_next     = 1'b1;
        dead_next     = 1'b0;
        case (state_next)
            ST_IDLE: begin
                busy_next = 1'b0;
            end
            ST_REQ: begin
                request_next  = 1'b1;
                complete_next = 1'b1;
            end
            ST_WRITE, ST_READ: begin
                complete_next = 1'b1;
            end
            ST_RETRY, ST_DONE: begin
                complete_next = 1'b0;
            end
            ST_DEAD: begin
                dead_next = 1'b1;
            end
            default: begin
                request_next = 1'b0;
            end
        endcase
    end

    // Data is always on hand, so the bus is never requested before this
    // block can move it and no wait states are inserted. A flip-flop rather
    // than a tie keeps the pin driven by logic.
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ready <= 1'b0;
        end else begin
            ready <= 1'b1;
        end
    end

    // The extended request stays low: single transfers never hold the bus.
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bus_request      <= 1'b0;
            extended_bus_ask <= 1'b0;
        end else begin
            bus_request      <= request_next;
            extended_bus_ask <= 1'b0;
        end
    end

    // Complete rises with the request itself, well inside the one clock that
    // the core allows, and drops the clock after the data phase ends.
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            complete <= 1'b0;
        end else begin
            complete <= complete_next;
        end
    end

    // A registered copy of dir; since dir is held from start to done, the
    // copy is constant through each transaction, one clock later.
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            user_write_direction <= 1'b0;
        end else begin
            user_write_direction <= dir;
        end
    end

    // Added status for the user: busy outside idle, dead until reset.
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            dead <= 1'b0;
        end else begin
            busy <= busy_next;
            dead <= dead_next;
        end
    end

    // Outputs are registered and cannot follow the strobe in the same clock,
    // so the address is presented from the request on and kept up until a
    // data phase takes the bus; a repeated strobe presents it again. The
    // strobe alone is no promise that a data phase will follow.
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            shared_addr_data_bus_oe  <= 1'b0;
            shared_addr_data_bus_out <= {ADDR_W{1'b0}};
        end else if (live_next) begin
            shared_addr_data_bus_oe  <= !phase_owns_bus;
            shared_addr_data_bus_out <= target_addr;
        end else begin
            shared_addr_data_bus_oe  <= 1'b0;
            shared_addr_data_bus_out <= {ADDR_W{1'b0}};
        end
    end

    // The command stands wherever the address does; in the data phase and
    // between transactions all byte enables are active. Other commands or
    // partial enables need only this block changed.
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            user_cmd_byte_en <= `PISX_BYTE_EN_ALL;
        end else if (live_next && !phase_owns_bus) begin
            user_cmd_byte_en <= mem_command(dir);
        end else begin
            user_cmd_byte_en <= `PISX_BYTE_EN_ALL;
        end
    end

endmodule // pisx_seq

// >>> pisx_seq_checker.sv
// Port assertions for the single-transfer initiator sequencer.
// Assumes one clock domain; bound to every pisx_seq instance.
`timescale 1ns/1ns
module pisx_seq_checker #(parameter ADDR_W = 32) (
    input wire              mclk, rst_n, start, dir, busy, dead, xfer_phase, addr_strobe_n,
    input wire              bus_request, extended_bus_ask, ready, complete,
    input wire              user_write_direction, shared_addr_data_bus_oe,
    input wire [3:0]        user_cmd_byte_en,
    input wire [ADDR_W-1:0] target_addr, shared_addr_data_bus_out
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    idle_start_a: assert property (start && !busy |=> bus_request) else $error("start not taken");
    req_pulse_a: assert property (bus_request |=> !bus_request) else $error("request too long");
    req_cmd_a: assert property (bus_request |-> complete && user_cmd_byte_en == {3'h3, $past(dir)})
        else $error("bad command or complete");
    addr_drive_a: assert property (shared_addr_data_bus_oe |-> shared_addr_data_bus_out == target_addr)
        else $error("bad address");
    data_release_a: assert property (xfer_phase |=> !shared_addr_data_bus_oe && user_cmd_byte_en == 4'h0)
        else $error("bus not released");
    phase_end_a: assert property ($fell(xfer_phase) |-> ##[1:2] !complete) else $error("complete stuck");
    strobe_addr_a: assert property (!addr_strobe_n |-> shared_addr_data_bus_oe
        && user_cmd_byte_en == {3'h3, user_write_direction}) else $error("address not presented at strobe");
    dead_hold_a: assert property (dead |=> dead && !bus_request) else $error("dead left");
    ask_zero_a: assert property (!extended_bus_ask) else $error("extended ask set");
    ready_high_a: assert property ($past(rst_n) |-> ready) else $error("ready low");
    dir_copy_a: assert property ($past(rst_n) |-> user_write_direction == $past(dir)) else $error("bad dir");
    cover property (dead);
    cover property ($fell(xfer_phase) ##2 bus_request);
    cover property (bus_request ##1 !bus_request && user_write_direction);
endmodule // pisx_seq_checker
bind pisx_seq pisx_seq_checker #(.ADDR_W(ADDR_W)) chk_i (.*);

// >>> pisx_core_model.sv
// Behavioural model of the core's initiator user port.
// Assumes the bus master enable is already set by configuration.
`timescale 1ns/1ns
module pisx_core_model (
    input  wire        mclk,
    input  wire        bus_request,
    input  wire [1:0]  mode,
    input  wire [1:0]  strobes,
    output reg         addr_strobe_n = 1'b1,
    output reg         xfer_phase = 1'b0,
    output reg  [39:0] core_ext_status = 40'h0
);
    reg [7:0] code;
    reg       again = 1'b0;
    integer   i;
    // Mode 0 ends cleanly, 1 retries once, 2 and 3 abort.
    always @(posedge mclk) if (bus_request) begin
        code = mode == 2'h1 && !again ? 8'h10 : mode == 2'h2 ? 8'h40 : mode == 2'h3 ? 8'h80 : 8'h00;
        again = mode == 2'h1 && !again;
        repeat (2) @(posedge mclk);
        for (i = 0; i <= strobes; i++) begin
            addr_strobe_n <= 1'b0;
            @(posedge mclk) addr_strobe_n <= 1'b1;
            repeat (2) @(posedge mclk);
        end
        xfer_phase <= 1'b1;
        core_ext_status <= {code, 32'h0};
        repeat (2) @(posedge mclk);
        xfer_phase <= 1'b0;
        core_ext_status <= {~code, 32'h0};
    end
endmodule // pisx_core_model

// >>> tb_pisx_seq.sv
// Self-checking bench for the initiator sequencer.
// Assumes the core model and the bound checker are compiled first.
`timescale 1ns/1ns
module tb_pisx_seq;
    reg          mclk = 0, rst_n = 0, start = 0, dir = 0;
    reg   [1:0]  mode = 0, strobes = 0;
    reg   [31:0] target_addr = 32'hA5C30F18;
    wire         busy, dead, asn, xp, breq, ask, ready, complete, wdir, oe;
    wire  [39:0] st;
    wire  [3:0]  cbe;
    wire  [31:0] aout;
    integer      err_count = 0, cmp_count = 0, reqs = 0, i;
    always #50 mclk = ~mclk;
    always @(posedge mclk) if (breq === 1'b1) reqs <= reqs + 1;
    pisx_seq uut (.mclk(mclk), .rst_n(rst_n), .start(start), .dir(dir), .target_addr(target_addr), .busy(busy),
        .dead(dead), .addr_strobe_n(asn), .xfer_phase(xp), .core_ext_status(st), .bus_request(breq),
        .extended_bus_ask(ask), .ready(ready), .complete(complete), .user_write_direction(wdir),
        .user_cmd_byte_en(cbe), .shared_addr_data_bus_out(aout), .shared_addr_data_bus_oe(oe));
    pisx_core_model core (.mclk(mclk), .bus_request(breq), .mode(mode), .strobes(strobes),
        .addr_strobe_n(asn), .xfer_phase(xp), .core_ext_status(st));
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %0h, seen %0h", n, e, g);
        end
    endtask
    task do_reset;
        rst_n = 0;
        start = 0;
        repeat (5) @(negedge mclk);
        chk("ready", 0, ready);
        chk("complete", 0, complete);
        rst_n = 1;
    endtask
    task run(input logic d, input logic [1:0] m, s, input logic ed, input logic [7:0] er);
        integer b;
        b = reqs;
        dir = d;
        mode = m;
        strobes = s;
        start = 1;
        @(negedge mclk) start = 0;
        for (i = 0; i < 80 && busy === 1'b1 && dead !== 1'b1; i++) @(negedge mclk);
        chk("dead", ed, dead);
        chk("busy", ed, busy);
        chk("requests", er, 8'(reqs - b));
        if (ed) begin
            start = 1;
            repeat (6) @(negedge mclk);
            chk("requests in dead", er, 8'(reqs - b));
        end
    endtask
    task tally_and_finish;
        $display("checks %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #200000;
        err_count++;
        tally_and_finish;
    end
    initial begin
        do_reset;
        run(1, 0, 0, 0, 1);
        run(0, 1, 1, 0, 2);
        run(1, 2, 0, 1, 1);
        do_reset;
        run(0, 3, 2, 1, 1);
        tally_and_finish;
    end
endmodule // tb_pisx_seq
